// File: hw/bidir_fifo_map.svh
`ifndef BIDIR_FIFO_MAP_SVH
`define BIDIR_FIFO_MAP_SVH

// Data bus width of both ports
`define BUS_WIDTH 36

// Almost-flag offsets per offset-select code
`define OFFSET_SEL_HH 5'h10
`define OFFSET_SEL_HL 5'h0C
`define OFFSET_SEL_LH 5'h08
`define OFFSET_SEL_LL 5'h04
`define OFFSET_RESET 5'h04

// Port A pin vector bits
`define PA_CLK 40
`define PA_SEL_N 39
`define PA_WNR 38
`define PA_EN 37
`define PA_MBX 36
`define PA_WIDTH 41

// Port B pin vector bits
`define PB_CLK 41
`define PB_SEL_N 40
`define PB_WNR 39
`define PB_EN 38
`define PB_PORT_B_SIZE_SEL1 37
`define PB_PORT_B_SIZE_SEL0 36
`define PB_WIDTH 42

// Misc pin vector bits
`define PM_RST_N 2
`define PM_FS1 1
`define PM_FS0 0
`define PM_WIDTH 3

// Four-flag group bits and reset value
`define FL_EMPTY 3
`define FL_AEMPTY 2
`define FL_AFULL 1
`define FL_FULL 0
`define FLAG_RESET 4'h2

`endif

// File: hw/bidir_fifo_pkg.sv
`include "bidir_fifo_map.svh"

package bidir_fifo_pkg;

    typedef logic [4:0] offset_t;
    typedef logic [`BUS_WIDTH-1:0] word_t;
    typedef logic [3:0] flags_t;

    // Whole state of the top module
    typedef struct packed {
        logic [`PA_WIDTH-1:0] a_s1, a_s2, a_s3, a_f;
        logic a_clk_prev;
        logic [`PB_WIDTH-1:0] b_s1, b_s2, b_s3, b_f;
        logic b_clk_prev;
        logic [`PM_WIDTH-1:0] m_s1, m_s2, m_s3, m_f;
        logic rst_n_prev;
        offset_t offset;
        word_t a2b_mbox, b2a_mbox;
        logic a2b_mb_n, b2a_mb_n;
        word_t a2b_outreg, b2a_outreg;
        word_t a_bus_out, b_bus_out;
        flags_t a_flag1, a_flag2, b_flag1, b_flag2;
    } top_state_t;

endpackage : bidir_fifo_pkg

// File: hw/bidir_fifo_ports.sv
// Operation
// R1: Outside party holds reset low across four edges of each port clock.
// R2: Reset pin may change at any moment, unrelated to either port clock.
// R3: Reset clears pointers; full, empty, almost-empty low; almost-full high.
// R4: Reset drives both mailbox flags high, marking mailboxes empty.
// R5: Full flags rise after two edges of their own port clock after reset.
// R6: Outside party resets the device after power-up before writing data.
// R7: Reset release loads offset X from selects: 16, 12, 8 or 4.
// R8: Port A drives its bus only while select low and write/read low.
// R9: Port A write with mailbox select low stores into A-to-B queue if not full.
// R10: Port A read with mailbox select low advances B-to-A word if not empty.
// R11: Port A shows queue output register or B-to-A mailbox by mailbox select.
// R12: Port A mailbox read sets the B-to-A mailbox flag high.
// R13: Port B drives its bus only while select low and write/read low.
// R14: Port B write, not both size selects high, stores into B-to-A queue.
// R15: Port B shows A-to-B output register; enabled read advances next word.
// R16: Port B with both size selects high shows mailbox; read sets its flag.
// R17: Enable low means no transfer; selects may then change freely.
// R18: Each queue flag passes two stages clocked by its port clock.
// R19: A flags follow port A clock; B flags follow port B clock.
// R20: Flags low at 0 words, X or fewer, 64-X or more, 64 words.
// R21: Port A mailbox write stores data and drives A-to-B mailbox flag low.
// R22: Port B mailbox write stores data and drives B-to-A mailbox flag low.
// R23: Mailbox writes ignored while its flag is low; reads keep contents.
// R24: Reads while empty and writes while full are ignored.
// R25: Queues use wrapping pointers with an extra wrap bit.
// R26: One offset X, loaded at reset, serves both queues until next reset.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Queue with valid/ready on both sides
module word_queue #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 64,
    parameter int AW = $clog2(DEPTH)
) (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic clear,
    // Fill side
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [WIDTH-1:0] wr_data,
    // Drain side
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [WIDTH-1:0] rd_data,
    // Fill level
    output logic [AW:0] level
);

    typedef struct packed {
        logic [AW:0] wr_ptr;
        logic [AW:0] rd_ptr;
    } queue_state_t;

    queue_state_t st_r, st_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic do_wr, do_rd;

    // Extra wrap bit tells full from empty
    assign level = st_r.wr_ptr - st_r.rd_ptr; // R25
    assign wr_ready = (level != (AW+1)'(DEPTH)); // R24
    assign rd_valid = (level != '0); // R24
    assign rd_data = mem[st_r.rd_ptr[AW-1:0]];
    assign do_wr = wr_valid & wr_ready & ~clear;
    assign do_rd = rd_valid & rd_ready & ~clear;

    // Pointer update
    always_comb
    begin
        st_nxt = st_r;
        if (clear)
        begin
            st_nxt.wr_ptr = '0; // R3
            st_nxt.rd_ptr = '0;
        end
        else
        begin
            if (do_wr)
                st_nxt.wr_ptr = st_r.wr_ptr + 1'b1; // R25
            if (do_rd)
                st_nxt.rd_ptr = st_r.rd_ptr + 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            st_r <= '0;
        else if (ce)
            st_r <= st_nxt;
    end

    // Storage has no reset; pointers guard stale words
    always_ff @(posedge mclk)
    begin
        if (ce && do_wr)
            mem[st_r.wr_ptr[AW-1:0]] <= wr_data;
    end

endmodule : word_queue

////////////////////////////////////////////////////////////////////////////////
// Two-port bidirectional queue pair with mailboxes
module bidir_fifo_ports #(
    parameter int DEPTH = 64
) (
    // System
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    // Device pins shared by both ports
    input wire logic device_reset_n,
    input wire logic offset_select0,
    input wire logic offset_select1,
    // Port A pins
    input wire logic port_a_clock,
    input wire logic port_a_select_n,
    input wire logic port_a_write_not_read,
    input wire logic port_a_enable,
    input wire logic port_a_mailbox_select,
    input wire logic [`BUS_WIDTH-1:0] port_a_bus_in,
    output logic [`BUS_WIDTH-1:0] port_a_bus_out,
    output logic port_a_bus_oe,
    output logic port_a_full_n,
    output logic port_a_almost_full_n,
    output logic port_a_empty_n,
    output logic port_a_almost_empty_n,
    output logic a_to_b_mailbox_flag_n,
    // Port B pins
    input wire logic port_b_clock,
    input wire logic port_b_select_n,
    input wire logic port_b_write_not_read,
    input wire logic port_b_enable,
    input wire logic port_b_size_sel0,
    input wire logic port_b_size_sel1,
    input wire logic [`BUS_WIDTH-1:0] port_b_bus_in,
    output logic [`BUS_WIDTH-1:0] port_b_bus_out,
    output logic port_b_bus_oe,
    output logic port_b_full_n,
    output logic port_b_almost_full_n,
    output logic port_b_empty_n,
    output logic port_b_almost_empty_n,
    output logic b_to_a_mailbox_flag_n
);

    localparam int AW = $clog2(DEPTH);

    bidir_fifo_pkg::top_state_t st_r, st_nxt;

    logic [`PA_WIDTH-1:0] a_pins;
    logic [`PB_WIDTH-1:0] b_pins;
    logic [`PM_WIDTH-1:0] m_pins;
    logic in_reset, a_edge, b_edge, a_wr, a_rd, b_wr, b_rd, b_mbx;
    logic a2b_wr_valid, a2b_wr_ready, a2b_rd_valid, a2b_rd_take;
    logic b2a_wr_valid, b2a_wr_ready, b2a_rd_valid, b2a_rd_take;
    logic [`BUS_WIDTH-1:0] a2b_rd_data, b2a_rd_data;
    logic [AW:0] a2b_level, b2a_level;
    bidir_fifo_pkg::flags_t a_raw, b_raw;

    ////////////////////////////////////////////////////////////////////////////
    // Pin vectors
    assign a_pins = {port_a_clock, port_a_select_n, port_a_write_not_read,
                     port_a_enable, port_a_mailbox_select, port_a_bus_in};
    assign b_pins = {port_b_clock, port_b_select_n, port_b_write_not_read,
                     port_b_enable, port_b_size_sel1, port_b_size_sel0, port_b_bus_in};
    assign m_pins = {device_reset_n, offset_select1, offset_select0};

    // Decode from filtered pins; control and data share one delay
    assign in_reset = ~st_r.m_f[`PM_RST_N]; // R2
    assign a_edge = st_r.a_f[`PA_CLK] & ~st_r.a_clk_prev;
    assign b_edge = st_r.b_f[`PB_CLK] & ~st_r.b_clk_prev;
    assign a_wr = ~st_r.a_f[`PA_SEL_N] & st_r.a_f[`PA_WNR] & st_r.a_f[`PA_EN]; // R17
    assign a_rd = ~st_r.a_f[`PA_SEL_N] & ~st_r.a_f[`PA_WNR] & st_r.a_f[`PA_EN]; // R17
    assign b_wr = ~st_r.b_f[`PB_SEL_N] & st_r.b_f[`PB_WNR] & st_r.b_f[`PB_EN]; // R17
    assign b_rd = ~st_r.b_f[`PB_SEL_N] & ~st_r.b_f[`PB_WNR] & st_r.b_f[`PB_EN]; // R17
    assign b_mbx = st_r.b_f[`PB_PORT_B_SIZE_SEL1] & st_r.b_f[`PB_PORT_B_SIZE_SEL0];

    // Queue transfers gated by the port's own synchronised flag
    assign a2b_wr_valid = a_edge & a_wr & ~st_r.a_f[`PA_MBX]
                          & st_r.a_flag2[`FL_FULL] & ~in_reset; // R9
    assign b2a_rd_take = a_edge & a_rd & ~st_r.a_f[`PA_MBX]
                         & st_r.a_flag2[`FL_EMPTY] & b2a_rd_valid & ~in_reset; // R10
    assign b2a_wr_valid = b_edge & b_wr & ~b_mbx
                          & st_r.b_flag2[`FL_FULL] & ~in_reset; // R14
    assign a2b_rd_take = b_edge & b_rd & ~b_mbx
                         & st_r.b_flag2[`FL_EMPTY] & a2b_rd_valid & ~in_reset; // R15

    ////////////////////////////////////////////////////////////////////////////
    // Queues
    word_queue #(.WIDTH(`BUS_WIDTH), .DEPTH(DEPTH), .AW(AW)) a_to_b_queue (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .clear(in_reset),
        .wr_valid(a2b_wr_valid),
        .wr_ready(a2b_wr_ready),
        .wr_data(st_r.a_f[`BUS_WIDTH-1:0]),
        .rd_valid(a2b_rd_valid),
        .rd_ready(a2b_rd_take),
        .rd_data(a2b_rd_data),
        .level(a2b_level)
    );

    word_queue #(.WIDTH(`BUS_WIDTH), .DEPTH(DEPTH), .AW(AW)) b_to_a_queue (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .clear(in_reset),
        .wr_valid(b2a_wr_valid),
        .wr_ready(b2a_wr_ready),
        .wr_data(st_r.b_f[`BUS_WIDTH-1:0]),
        .rd_valid(b2a_rd_valid),
        .rd_ready(b2a_rd_take),
        .rd_data(b2a_rd_data),
        .level(b2a_level)
    );

    // Raw flags: {empty_n, almost_empty_n, almost_full_n, full_n}
    always_comb
    begin
        a_raw = {b2a_rd_valid, // R20
                 (b2a_level > (AW+1)'(st_r.offset)), // R26
                 (a2b_level < ((AW+1)'(DEPTH) - (AW+1)'(st_r.offset))), // R20
                 a2b_wr_ready}; // R19
        b_raw = {a2b_rd_valid, // R20
                 (a2b_level > (AW+1)'(st_r.offset)), // R26
                 (b2a_level < ((AW+1)'(DEPTH) - (AW+1)'(st_r.offset))), // R20
                 b2a_wr_ready}; // R19
    end

    ////////////////////////////////////////////////////////////////////////////
    // Offset decode
    function automatic bidir_fifo_pkg::offset_t decode_offset(input logic [1:0] fs);
        unique case (fs)
            2'h3: decode_offset = `OFFSET_SEL_HH;
            2'h2: decode_offset = `OFFSET_SEL_HL;
            2'h1: decode_offset = `OFFSET_SEL_LH;
            2'h0: decode_offset = `OFFSET_SEL_LL;
        endcase
    endfunction : decode_offset

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        st_nxt = st_r;
        // Three-stage pin capture; a bit changes once stages two and three agree
        st_nxt.a_s1 = a_pins;
        st_nxt.a_s2 = st_r.a_s1;
        st_nxt.a_s3 = st_r.a_s2;
        st_nxt.a_f = (~(st_r.a_s2 ^ st_r.a_s3) & st_r.a_s3)
                     | ((st_r.a_s2 ^ st_r.a_s3) & st_r.a_f);
        st_nxt.b_s1 = b_pins;
        st_nxt.b_s2 = st_r.b_s1;
        st_nxt.b_s3 = st_r.b_s2;
        st_nxt.b_f = (~(st_r.b_s2 ^ st_r.b_s3) & st_r.b_s3)
                     | ((st_r.b_s2 ^ st_r.b_s3) & st_r.b_f);
        st_nxt.m_s1 = m_pins; // R2
        st_nxt.m_s2 = st_r.m_s1;
        st_nxt.m_s3 = st_r.m_s2;
        st_nxt.m_f = (~(st_r.m_s2 ^ st_r.m_s3) & st_r.m_s3)
                     | ((st_r.m_s2 ^ st_r.m_s3) & st_r.m_f);
        st_nxt.a_clk_prev = st_r.a_f[`PA_CLK];
        st_nxt.b_clk_prev = st_r.b_f[`PB_CLK];
        st_nxt.rst_n_prev = st_r.m_f[`PM_RST_N];

        // Offset taken once on reset release, held until next reset
        if (st_r.m_f[`PM_RST_N] && !st_r.rst_n_prev)
            st_nxt.offset = decode_offset(st_r.m_f[`PM_FS1:`PM_FS0]); // R7 R26

        // Queue output registers load only on an accepted read
        if (b2a_rd_take)
            st_nxt.b2a_outreg = b2a_rd_data; // R10
        if (a2b_rd_take)
            st_nxt.a2b_outreg = a2b_rd_data; // R15

        // Mailbox reads first, so a write in the same cycle wins the flag
        if (b_edge && b_rd && b_mbx)
            st_nxt.a2b_mb_n = 1'b1; // R16
        if (a_edge && a_rd && st_r.a_f[`PA_MBX])
            st_nxt.b2a_mb_n = 1'b1; // R12
        if (a_edge && a_wr && st_r.a_f[`PA_MBX] && st_r.a2b_mb_n)
        begin
            st_nxt.a2b_mbox = st_r.a_f[`BUS_WIDTH-1:0]; // R21 R23
            st_nxt.a2b_mb_n = 1'b0; // R21
        end
        if (b_edge && b_wr && b_mbx && st_r.b2a_mb_n)
        begin
            st_nxt.b2a_mbox = st_r.b_f[`BUS_WIDTH-1:0]; // R22 R23
            st_nxt.b2a_mb_n = 1'b0; // R22
        end

        // Two flag stages, each advanced by its own port clock edge
        if (a_edge)
        begin
            st_nxt.a_flag1 = a_raw; // R18 R19
            st_nxt.a_flag2 = st_r.a_flag1; // R18
        end
        if (b_edge)
        begin
            st_nxt.b_flag1 = b_raw; // R18 R19
            st_nxt.b_flag2 = st_r.b_flag1; // R18
        end

        // Device reset pin holds flags; full flags climb back in two edges
        if (in_reset)
        begin
            st_nxt.a_flag1 = `FLAG_RESET; // R3 R5
            st_nxt.a_flag2 = `FLAG_RESET; // R3
            st_nxt.b_flag1 = `FLAG_RESET; // R3 R5
            st_nxt.b_flag2 = `FLAG_RESET; // R3
            st_nxt.a2b_mb_n = 1'b1; // R4
            st_nxt.b2a_mb_n = 1'b1; // R4
        end

        // Output data from flip-flops, chosen by mailbox or size selects
        st_nxt.a_bus_out = st_r.a_f[`PA_MBX] ? st_r.b2a_mbox : st_r.b2a_outreg; // R11
        st_nxt.b_bus_out = b_mbx ? st_r.a2b_mbox : st_r.a2b_outreg; // R15 R16
    end

    // Whole-block state; clock enable low freezes everything
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            st_r <= '0;
            st_r.offset <= `OFFSET_RESET;
            st_r.a2b_mb_n <= 1'b1;
            st_r.b2a_mb_n <= 1'b1;
            st_r.a_flag1 <= `FLAG_RESET;
            st_r.a_flag2 <= `FLAG_RESET;
            st_r.b_flag1 <= `FLAG_RESET;
            st_r.b_flag2 <= `FLAG_RESET;
        end
        else if (ce)
            st_r <= st_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs; combinational enables keep turnaround short
    assign port_a_bus_oe = ~st_r.a_f[`PA_SEL_N] & ~st_r.a_f[`PA_WNR]; // R8
    assign port_b_bus_oe = ~st_r.b_f[`PB_SEL_N] & ~st_r.b_f[`PB_WNR]; // R13
    assign port_a_bus_out = st_r.a_bus_out;
    assign port_b_bus_out = st_r.b_bus_out;
    assign port_a_empty_n = st_r.a_flag2[`FL_EMPTY];
    assign port_a_almost_empty_n = st_r.a_flag2[`FL_AEMPTY];
    assign port_a_almost_full_n = st_r.a_flag2[`FL_AFULL];
    assign port_a_full_n = st_r.a_flag2[`FL_FULL];
    assign port_b_empty_n = st_r.b_flag2[`FL_EMPTY];
    assign port_b_almost_empty_n = st_r.b_flag2[`FL_AEMPTY];
    assign port_b_almost_full_n = st_r.b_flag2[`FL_AFULL];
    assign port_b_full_n = st_r.b_flag2[`FL_FULL];
    assign a_to_b_mailbox_flag_n = st_r.a2b_mb_n;
    assign b_to_a_mailbox_flag_n = st_r.b2a_mb_n;

endmodule : bidir_fifo_ports

`default_nettype wire

// File: verif/bidir_fifo_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module fifo_port_checker (
    // System
    input wire logic mclk,
    input wire logic rst,
    input wire logic device_reset_n,
    // Port A
    input wire logic port_a_clock,
    input wire logic port_a_select_n,
    input wire logic port_a_write_not_read,
    input wire logic port_a_mailbox_select,
    input wire logic port_a_bus_oe,
    input wire logic port_a_full_n,
    input wire logic port_a_almost_full_n,
    input wire logic port_a_empty_n,
    input wire logic port_a_almost_empty_n,
    input wire logic a_to_b_mailbox_flag_n,
    // Port B
    input wire logic port_b_write_not_read,
    input wire logic port_b_size_sel0,
    input wire logic port_b_size_sel1,
    input wire logic port_b_bus_oe,
    input wire logic b_to_a_mailbox_flag_n
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    logic [5:0] clk_h;
    logic [5:0] dr_h;

    ////////////////////////////////////////////////////////////////////////////
    // Pin history; reset to permissive values
    always_ff @(posedge mclk)
    begin
        clk_h <= rst ? 6'h3F : {clk_h[4:0], port_a_clock};
        dr_h <= rst ? 6'h00 : {dr_h[4:0], device_reset_n};
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin filters delay decode; selects must sit eight cycles
    property p_oe_a_on;
        (!port_a_select_n && !port_a_write_not_read) [*8] |-> port_a_bus_oe;
    endproperty
    a_oe_a_on: assert property (p_oe_a_on) else $error("port A bus not driven");
    property p_oe_a_off;
        port_a_select_n [*8] |-> !port_a_bus_oe;
    endproperty
    a_oe_a_off: assert property (p_oe_a_off) else $error("port A bus driven");
    property p_oe_b_off;
        port_b_write_not_read [*8] |-> !port_b_bus_oe;
    endproperty
    a_oe_b_off: assert property (p_oe_b_off) else $error("port B bus driven");
    property p_rst_flags;
        (!device_reset_n) [*8] |-> !port_a_full_n && !port_a_empty_n
            && !port_a_almost_empty_n && port_a_almost_full_n;
    endproperty
    a_rst_flags: assert property (p_rst_flags) else $error("flags wrong in reset");
    property p_rst_mbox;
        (!device_reset_n) [*8] |-> a_to_b_mailbox_flag_n && b_to_a_mailbox_flag_n;
    endproperty
    a_rst_mbox: assert property (p_rst_mbox) else $error("mail flags low in reset");
    property p_mbox_set;
        $fell(a_to_b_mailbox_flag_n) |->
            $past(port_a_mailbox_select, 3) && $past(port_a_write_not_read, 3);
    endproperty
    a_mbox_set: assert property (p_mbox_set) else $error("mail flag fell untold");
    property p_mbox_a_rd;
        $rose(b_to_a_mailbox_flag_n) |-> !(&dr_h)
            || ($past(port_a_mailbox_select, 3) && !$past(port_a_write_not_read, 3));
    endproperty
    a_mbox_a_rd: assert property (p_mbox_a_rd) else $error("mail flag rose untold");
    property p_mbox_b_rd;
        $rose(a_to_b_mailbox_flag_n) |-> !(&dr_h) || ($past(port_b_size_sel0, 3)
            && $past(port_b_size_sel1, 3) && !$past(port_b_write_not_read, 3));
    endproperty
    a_mbox_b_rd: assert property (p_mbox_b_rd) else $error("mail flag rose untold");
    property p_empty_ae;
        !port_a_empty_n |-> !port_a_almost_empty_n;
    endproperty
    a_empty_ae: assert property (p_empty_ae) else $error("empty but not low");
    property p_flag_sync;
        $changed(port_a_empty_n) |-> (|clk_h[5:2]) || !(&dr_h);
    endproperty
    a_flag_sync: assert property (p_flag_sync) else $error("flag moved off edge");

    // Main scenarios
    c_mail: cover property ($fell(a_to_b_mailbox_flag_n));
    c_full: cover property (device_reset_n && $fell(port_a_full_n));
    c_data: cover property ($rose(port_a_empty_n));
endmodule : fifo_port_checker

bind bidir_fifo_ports fifo_port_checker fifo_port_checker_inst (
    .mclk(mclk), .rst(rst), .device_reset_n(device_reset_n),
    .port_a_clock(port_a_clock), .port_a_select_n(port_a_select_n),
    .port_a_write_not_read(port_a_write_not_read),
    .port_a_mailbox_select(port_a_mailbox_select), .port_a_bus_oe(port_a_bus_oe),
    .port_a_full_n(port_a_full_n), .port_a_almost_full_n(port_a_almost_full_n),
    .port_a_empty_n(port_a_empty_n), .port_a_almost_empty_n(port_a_almost_empty_n),
    .a_to_b_mailbox_flag_n(a_to_b_mailbox_flag_n),
    .port_b_write_not_read(port_b_write_not_read), .port_b_size_sel0(port_b_size_sel0),
    .port_b_size_sel1(port_b_size_sel1), .port_b_bus_oe(port_b_bus_oe),
    .b_to_a_mailbox_flag_n(b_to_a_mailbox_flag_n));

`default_nettype wire

// File: verif/port_clock_source.sv
`timescale 1ns/1ps
`default_nettype none

module port_clock_source #(
    parameter int HALF_A = 8,
    parameter int HALF_B = 9
) (
    // System clock
    input wire logic mclk,
    // Free-running port clocks
    output logic port_a_clock,
    output logic port_b_clock
);
    int cnt_a = 0, cnt_b = 0;

    // Unequal halves drift the ports; both exceed the filter delay
    initial
    begin
        port_a_clock = 1'b0;
        port_b_clock = 1'b0;
    end
    always @(negedge mclk)
    begin
        cnt_a = (cnt_a == HALF_A - 1) ? 0 : cnt_a + 1;
        cnt_b = (cnt_b == HALF_B - 1) ? 0 : cnt_b + 1;
        if (cnt_a == 0)
            port_a_clock = ~port_a_clock;
        if (cnt_b == 0)
            port_b_clock = ~port_b_clock;
    end
endmodule : port_clock_source

`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic dev_rst_n = 1'b0;
    logic fs0 = 1'b0, fs1 = 1'b0, a_clk, b_clk;
    logic a_sel_n = 1'b1, a_wnr = 1'b1, a_en = 1'b0, a_mbx = 1'b0;
    logic b_sel_n = 1'b1, b_wnr = 1'b1, b_en = 1'b0, b_s1 = 1'b0, b_s0 = 1'b0;
    bidir_fifo_pkg::word_t a_in = '0, b_in = '0, a_out, b_out;
    logic a_oe, a_ff, a_af, a_ef, a_ae, a_mf, b_oe, b_ff, b_af, b_ef, b_ae, b_mf;
    int fail_count = 0;
    int samples_checked = 0;

    always #12.5 mclk = ~mclk;

    port_clock_source port_clock_source_inst (.mclk(mclk), .port_a_clock(a_clk),
        .port_b_clock(b_clk));

    bidir_fifo_ports bidir_fifo_ports_inst (.mclk(mclk), .rst(rst), .ce(1'b1),
        .device_reset_n(dev_rst_n), .offset_select0(fs0), .offset_select1(fs1),
        .port_a_clock(a_clk), .port_a_select_n(a_sel_n), .port_a_write_not_read(a_wnr),
        .port_a_enable(a_en), .port_a_mailbox_select(a_mbx), .port_a_bus_in(a_in),
        .port_a_bus_out(a_out), .port_a_bus_oe(a_oe), .port_a_full_n(a_ff),
        .port_a_almost_full_n(a_af), .port_a_empty_n(a_ef), .port_a_almost_empty_n(a_ae),
        .a_to_b_mailbox_flag_n(a_mf), .port_b_clock(b_clk), .port_b_select_n(b_sel_n),
        .port_b_write_not_read(b_wnr), .port_b_enable(b_en), .port_b_size_sel0(b_s0),
        .port_b_size_sel1(b_s1), .port_b_bus_in(b_in), .port_b_bus_out(b_out),
        .port_b_bus_oe(b_oe), .port_b_full_n(b_ff), .port_b_almost_full_n(b_af),
        .port_b_empty_n(b_ef), .port_b_almost_empty_n(b_ae), .b_to_a_mailbox_flag_n(b_mf));

    ////////////////////////////////////////////////////////////////////////////
    // Compare helpers and closing
    function automatic bidir_fifo_pkg::word_t w(input int i);
        return bidir_fifo_pkg::word_t'(i) ^ 36'hC3C3C3C3C;
    endfunction : w
    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk_bit
    task automatic chk_word(input bidir_fifo_pkg::word_t got, exp);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t word %h expected %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic wrap_up();
        if (fail_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    ////////////////////////////////////////////////////////////////////////////
    // Port cycles hold pins a whole port period to cover the filter delay
    task automatic op_a(input logic en, input logic wnr, input logic mbx,
            input bidir_fifo_pkg::word_t d);
        @(negedge a_clk);
        a_sel_n = 1'b0;
        a_wnr = wnr;
        a_en = en;
        a_mbx = mbx;
        a_in = d;
        @(negedge a_clk);
        a_en = 1'b0;
        a_in = ~d;
    endtask : op_a
    task automatic op_b(input logic en, input logic wnr, input logic s1, input logic s0,
            input bidir_fifo_pkg::word_t d);
        @(negedge b_clk);
        b_sel_n = 1'b0;
        b_wnr = wnr;
        b_en = en;
        b_s1 = s1;
        b_s0 = s0;
        b_in = d;
        @(negedge b_clk);
        b_en = 1'b0;
        b_in = ~d;
    endtask : op_b
    task automatic fill_a(input int start, input int n);
        for (int i = 0; i < n; i++)
            op_a(1'b1, 1'b1, 1'b0, w(start + i));
    endtask : fill_a
    task automatic dev_reset(input logic s1, input logic s0);
        @(negedge a_clk);
        dev_rst_n = 1'b0;
        fs1 = s1;
        fs0 = s0;
        repeat (5) @(negedge b_clk);
        chk_word(36'({a_ff, a_ef, a_ae, a_af, b_ff, b_ef, b_ae, b_af, a_mf, b_mf}),
            36'h000000047);
        @(negedge a_clk);
        dev_rst_n = 1'b1;
        @(negedge a_clk);
        chk_bit(a_ff, 1'b0);
        @(negedge a_clk);
        chk_bit(a_ff, 1'b1);
        repeat (3) @(negedge b_clk);
        chk_bit(b_ff, 1'b1);
    endtask : dev_reset

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_a_to_b();
        op_a(1'b0, 1'b1, 1'b0, w(90));
        repeat (4) @(negedge b_clk);
        chk_bit(b_ef, 1'b0);
        fill_a(0, 3);
        repeat (4) @(negedge b_clk);
        chk_bit(b_ef, 1'b1);
        for (int i = 0; i < 3; i++)
        begin
            op_b(1'b1, 1'b0, 1'b0, 1'b0, '0);
            chk_word(b_out, w(i));
        end
        repeat (4) @(negedge b_clk);
        chk_bit(b_ef, 1'b0);
        op_b(1'b1, 1'b0, 1'b0, 1'b0, '0);
        chk_word(b_out, w(2));
        chk_bit(b_oe, 1'b1);
        b_wnr = 1'b1;
        repeat (6) @(negedge mclk);
        chk_bit(b_oe, 1'b0);
    endtask : t_a_to_b
    task automatic t_b_to_a();
        for (int i = 0; i < 2; i++)
            op_b(1'b1, 1'b1, 1'b1, 1'b0, w(10 + i));
        repeat (4) @(negedge a_clk);
        for (int i = 0; i < 2; i++)
        begin
            op_a(1'b1, 1'b0, 1'b0, '0);
            chk_word(a_out, w(10 + i));
        end
        a_sel_n = 1'b1;
        repeat (6) @(negedge mclk);
        chk_bit(a_oe, 1'b0);
    endtask : t_b_to_a
    task automatic t_mailbox();
        op_a(1'b1, 1'b1, 1'b1, w(20));
        chk_bit(a_mf, 1'b0);
        op_a(1'b1, 1'b1, 1'b1, w(21));
        op_b(1'b1, 1'b0, 1'b1, 1'b1, '0);
        chk_word(b_out, w(20));
        chk_bit(a_mf, 1'b1);
        op_b(1'b1, 1'b1, 1'b1, 1'b1, w(22));
        chk_bit(b_mf, 1'b0);
        op_a(1'b1, 1'b0, 1'b1, '0);
        chk_word(a_out, w(22));
        chk_bit(b_mf, 1'b1);
    endtask : t_mailbox
    task automatic t_offsets();
        int x;
        for (int c = 3; c >= 0; c--)
        begin
            x = 4 * (c + 1);
            dev_reset(c[1], c[0]);
            fill_a(0, x);
            repeat (4) @(negedge b_clk);
            chk_bit(b_ae, 1'b0);
            fill_a(x, 1);
            repeat (4) @(negedge b_clk);
            chk_bit(b_ae, 1'b1);
        end
        // Offset is 4 here with five words queued
        fill_a(5, 54);
        repeat (3) @(negedge a_clk);
        chk_bit(a_af, 1'b1);
        fill_a(59, 1);
        repeat (3) @(negedge a_clk);
        chk_bit(a_af, 1'b0);
        fill_a(60, 4);
        repeat (3) @(negedge a_clk);
        chk_bit(a_ff, 1'b0);
        fill_a(99, 1);
        repeat (4) @(negedge b_clk);
        for (int i = 0; i < 64; i++)
        begin
            op_b(1'b1, 1'b0, 1'b0, 1'b0, '0);
            chk_word(b_out, w(i));
        end
        fill_a(64, 1);
        repeat (4) @(negedge b_clk);
        op_b(1'b1, 1'b0, 1'b0, 1'b0, '0);
        chk_word(b_out, w(64));
    endtask : t_offsets

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial
    begin
        repeat (3) @(negedge mclk);
        rst = 1'b0;
        dev_reset(1'b0, 1'b0);
        t_a_to_b();
        t_b_to_a();
        t_mailbox();
        t_offsets();
        wrap_up();
    end
    initial
    begin
        repeat (30000) @(posedge mclk);
        fail_count++;
        wrap_up();
    end
endmodule : testbench

`default_nettype wire
